// File: qdc_pkg.sv
// constants and types shared by the quad converter serial control block
`default_nettype none
package qdc_pkg;
  // -----------------------------------------------------------------
  // serial frame layout
  // -----------------------------------------------------------------
  localparam int          WORD_BITS  = 12;
  localparam logic [3:0]  LAST_BIT   = 4'hB;
  localparam int          START_BIT  = 11;
  localparam int          TYPE_BIT   = 10;
  localparam int          SEL_HI     = 9;
  localparam int          SEL_LO     = 8;
  localparam int          CODE_MSB   = 7;
  localparam int          CODE_W     = 8;
  localparam logic [7:0]  CODE_RESET = 8'h00;
  // -----------------------------------------------------------------
  // control word fields
  // -----------------------------------------------------------------
  localparam int          CTRL_W        = 10;
  localparam int          CTRL_MODE     = 9;
  localparam int          CTRL_GAIN_LSB = 5;
  localparam int          CTRL_HOLD_LSB = 1;
  localparam int          CTRL_ACT      = 0;
  localparam logic [9:0]  CTRL_RESET    = 10'h1E0;
  // -----------------------------------------------------------------
  // channels, word queue and pin sampling
  // -----------------------------------------------------------------
  localparam int          NUM_CH     = 4;
  localparam int          ENT_W      = 13;
  localparam int          MARK_BIT   = 12;
  localparam int          FIFO_DEPTH = 16;
  localparam int          PIN_W      = 3;
  localparam int          PIN_CLK    = 0;
  localparam int          PIN_DATA   = 1;
  localparam int          PIN_EN     = 2;
  localparam logic [12:0] MARK_ENTRY = 13'h1000;

  typedef enum logic {ST_TAKE, ST_APPLY} qdc_state_e;
endpackage
`default_nettype wire

// File: qdc_fifo.sv
// parameterised valid/ready word queue
`timescale 1ns/1ps
`default_nettype none
module qdc_fifo #(
  parameter int W = 13,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  // -----------------------------------------------------------------
  // status
  // -----------------------------------------------------------------
  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q[AW-1:0]];

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // qdc_fifo
`default_nettype wire

// File: qdc_top.sv
// serial write interface and control logic of a four channel converter
//
// Summary of operation
// - enable high: from the start bit on, shift bit each serial falling edge
// - enable low: serial edges ignored, nothing loaded
// - single mode: update output on twelfth edge
// - double mode default: update all on enable fall
// - mode one selects single; sticky once set
// - control word setting single latches pending data
// - double mode: newer block overwrites same channel
// - enable fall ends transfer; latches held data in double mode only
// - control register holds ten active bits
// - gain bit: zero unity, one double
// - channel on if hold bit, else activation
// - activate bit ORed with asynchronous wake pin
// - two select bits pick channel a..d
// - reset leaves all channels shut down
// - reset control: mode0 gain1 hold0 act0
// - reset clears every held output code
// - codes are unsigned eight bit values
`timescale 1ns/1ps
`default_nettype none
module qdc_top (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       serial_clk,
  input  wire logic       serial_data,
  input  wire logic       enable,
  input  wire logic       hardware_wake_pin,
  output logic      [7:0] output_a,
  output logic      [7:0] output_b,
  output logic      [7:0] output_c,
  output logic      [7:0] output_d,
  output logic            gain_select_a,
  output logic            gain_select_b,
  output logic            gain_select_c,
  output logic            gain_select_d,
  output logic            channel_on_a,
  output logic            channel_on_b,
  output logic            channel_on_c,
  output logic            channel_on_d,
  output logic            single_mode,
  output logic            link_ready
);
  // -----------------------------------------------------------------
  // frame decoding helpers
  // -----------------------------------------------------------------
  // a word with the type bit set carries the control register
  function automatic logic is_ctrl(input logic [11:0] w);
    is_ctrl = w[qdc_pkg::TYPE_BIT];
  endfunction

  // channel select, high bit first on the wire
  function automatic logic [1:0] chan_of(input logic [11:0] w);
    chan_of = {w[qdc_pkg::SEL_HI], w[qdc_pkg::SEL_LO]};
  endfunction

  // -----------------------------------------------------------------
  // pin sampling
  // -----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] flt_q;
  logic [2:0] prev_q;
  logic       clk_fall;
  logic       en_fall;
  logic       en_lvl;
  logic       bit_in;

  assign pin_raw[qdc_pkg::PIN_CLK]  = serial_clk;
  assign pin_raw[qdc_pkg::PIN_DATA] = serial_data;
  assign pin_raw[qdc_pkg::PIN_EN]   = enable;

  // three stage chain; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < qdc_pkg::PIN_W; gi++) begin : g_flt
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          flt_q[gi]  <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
          prev_q[gi] <= flt_q[gi];
        end
      end
    end
  endgenerate

  // data and clock share the same delay, so setup is preserved
  assign en_lvl   = flt_q[qdc_pkg::PIN_EN];
  assign bit_in   = flt_q[qdc_pkg::PIN_DATA];
  assign clk_fall = prev_q[qdc_pkg::PIN_CLK] && !flt_q[qdc_pkg::PIN_CLK];
  assign en_fall  = prev_q[qdc_pkg::PIN_EN] && !en_lvl;

  // -----------------------------------------------------------------
  // input shift register
  // -----------------------------------------------------------------
  logic [10:0] shift_q;
  logic [3:0]  cnt_q;
  logic [11:0] word_q;
  logic        word_vld_q;

  // idle zeros before the start bit are skipped, which is how a
  // run of twelve zeros brings the frame back into step
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shift_q    <= 11'h000;
      cnt_q      <= 4'h0;
      word_q     <= 12'h000;
      word_vld_q <= 1'b0;
    end else begin
      word_vld_q <= 1'b0;
      if (!en_lvl) begin
        cnt_q <= 4'h0;
      end else if (clk_fall) begin
        if ((cnt_q != 4'h0) || bit_in) begin
          shift_q <= {shift_q[9:0], bit_in};
          if (cnt_q == qdc_pkg::LAST_BIT) begin
            cnt_q      <= 4'h0;
            word_q     <= {shift_q, bit_in};
            word_vld_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // word queue
  // -----------------------------------------------------------------
  logic        mark_pend_q;
  logic        q_in_valid;
  logic        q_in_ready;
  logic [12:0] q_in_data;
  logic        q_out_valid;
  logic        q_out_ready;
  logic [12:0] q_out_data;

  // the enable fall travels as a marker behind the words before it,
  // so the latch never overtakes data still in the queue
  assign q_in_valid = word_vld_q || mark_pend_q;
  assign q_in_data  = word_vld_q ? {1'b0, word_q} : qdc_pkg::MARK_ENTRY;
  assign link_ready = q_in_ready;

  // a new enable fall wins over the clear of the previous one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mark_pend_q <= 1'b0;
    end else if (en_fall) begin
      mark_pend_q <= 1'b1;
    end else if (!word_vld_q && q_in_ready) begin
      mark_pend_q <= 1'b0;
    end
  end

  // a word that meets a full queue is lost; link_ready shows it
  qdc_fifo #(
    .W (qdc_pkg::ENT_W),
    .D (qdc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .nrst      (nrst),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in_data),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data)
  );

  // -----------------------------------------------------------------
  // word decoder
  // -----------------------------------------------------------------
  qdc_pkg::qdc_state_e st_q;
  logic [12:0]         ent_q;
  logic [11:0]         ent_word;
  logic                ent_mark;
  logic                ent_ctrl;
  logic [9:0]          new_ctrl;

  // the decoder takes one entry every other cycle and stalls the queue
  assign q_out_ready = (st_q == qdc_pkg::ST_TAKE);
  assign ent_word    = ent_q[11:0];
  assign ent_mark    = ent_q[qdc_pkg::MARK_BIT];
  assign ent_ctrl    = is_ctrl(ent_word);
  assign new_ctrl    = ent_word[qdc_pkg::CTRL_W-1:0];

  // take / apply sequence
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q  <= qdc_pkg::ST_TAKE;
      ent_q <= 13'h0000;
    end else begin
      case (st_q)
        qdc_pkg::ST_TAKE: begin
          if (q_out_valid) begin
            ent_q <= q_out_data;
            st_q  <= qdc_pkg::ST_APPLY;
          end
        end
        qdc_pkg::ST_APPLY: begin
          st_q <= qdc_pkg::ST_TAKE;
        end
        default: begin
          st_q <= qdc_pkg::ST_TAKE;
        end
      endcase
    end
  end

  logic apply;
  assign apply = (st_q == qdc_pkg::ST_APPLY);

  // -----------------------------------------------------------------
  // entry classification
  // -----------------------------------------------------------------
  logic ctrl_hit;
  logic data_hit;
  logic mark_hit;

  // at most one of these is high, and only in an apply cycle
  assign ctrl_hit = apply && !ent_mark && ent_ctrl;
  assign data_hit = apply && !ent_mark && !ent_ctrl;
  assign mark_hit = apply && ent_mark;

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  logic [9:0] ctrl_q;
  logic       mode_q;
  logic [3:0] hold_bits;
  logic       act_bit;

  // ten write-only bits; the mode bit can be set but never cleared
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= qdc_pkg::CTRL_RESET;
    end else if (ctrl_hit) begin
      ctrl_q <= new_ctrl;
      ctrl_q[qdc_pkg::CTRL_MODE] <= new_ctrl[qdc_pkg::CTRL_MODE] | mode_q;
    end
  end

  assign mode_q    = ctrl_q[qdc_pkg::CTRL_MODE];
  assign hold_bits = ctrl_q[qdc_pkg::CTRL_HOLD_LSB +: qdc_pkg::NUM_CH];
  assign act_bit   = ctrl_q[qdc_pkg::CTRL_ACT];
  assign single_mode = mode_q;

  // -----------------------------------------------------------------
  // holding and output registers
  // -----------------------------------------------------------------
  logic [7:0] held_q [qdc_pkg::NUM_CH];
  logic [7:0] out_q  [qdc_pkg::NUM_CH];
  logic [3:0] gain_q;
  logic       go_single;
  logic       latch_all;
  logic [1:0] ent_ch;

  assign ent_ch    = chan_of(ent_word);
  assign go_single = ctrl_hit
                   && new_ctrl[qdc_pkg::CTRL_MODE] && !mode_q;
  // an enable fall latches only in double mode; entering single mode
  // also flushes what was pending
  assign latch_all = (mark_hit && !mode_q) || go_single;

  // codes: holding copy always written, output copy per mode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < qdc_pkg::NUM_CH; i++) begin
        held_q[i] <= qdc_pkg::CODE_RESET;
        out_q[i]  <= qdc_pkg::CODE_RESET;
      end
    end else if (latch_all) begin
      out_q <= held_q;
    end else if (data_hit) begin
      // later block for the same channel replaces the earlier one
      held_q[ent_ch] <= ent_word[qdc_pkg::CODE_MSB:0];
      if (mode_q) begin
        out_q[ent_ch] <= ent_word[qdc_pkg::CODE_MSB:0];
      end
    end
  end

  // gain bits follow the same update moment as the codes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gain_q <= qdc_pkg::CTRL_RESET[qdc_pkg::CTRL_GAIN_LSB +: qdc_pkg::NUM_CH];
    end else if (go_single || (mode_q && ctrl_hit)) begin
      gain_q <= new_ctrl[qdc_pkg::CTRL_GAIN_LSB +: qdc_pkg::NUM_CH];
    end else if (mark_hit && !mode_q) begin
      gain_q <= ctrl_q[qdc_pkg::CTRL_GAIN_LSB +: qdc_pkg::NUM_CH];
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  logic [3:0] chan_on;

  // the wake pin bypasses every flip-flop so it acts without a clock;
  // after reset act and hold are zero, so channels stay shut down
  assign chan_on = hold_bits | {4{act_bit | hardware_wake_pin}};

  assign output_a      = out_q[0];
  assign output_b      = out_q[1];
  assign output_c      = out_q[2];
  assign output_d      = out_q[3];
  // 0 selects unity gain, 1 double gain
  assign gain_select_a = gain_q[0];
  assign gain_select_b = gain_q[1];
  assign gain_select_c = gain_q[2];
  assign gain_select_d = gain_q[3];
  assign channel_on_a  = chan_on[0];
  assign channel_on_b  = chan_on[1];
  assign channel_on_c  = chan_on[2];
  assign channel_on_d  = chan_on[3];
endmodule // qdc_top
`default_nettype wire

// File: qdc_top_properties.sv
// concurrent checks on the quad converter control block ports
`timescale 1ns/1ps
`default_nettype none
module qdc_top_properties (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       serial_clk,
  input wire logic       serial_data,
  input wire logic       enable,
  input wire logic       hardware_wake_pin,
  input wire logic [7:0] output_a,
  input wire logic [7:0] output_b,
  input wire logic [7:0] output_c,
  input wire logic [7:0] output_d,
  input wire logic       gain_select_a,
  input wire logic       gain_select_b,
  input wire logic       gain_select_c,
  input wire logic       gain_select_d,
  input wire logic       channel_on_a,
  input wire logic       channel_on_b,
  input wire logic       channel_on_c,
  input wire logic       channel_on_d,
  input wire logic       single_mode,
  input wire logic       link_ready
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic       en_q;
  logic       sclk_q;
  logic [5:0] low_cnt_q;
  logic [5:0] since_fall_q;
  logic [5:0] since_clk_q;
  // raw pin is watched; bounds below leave slack for the pin filter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_q         <= 1'b0;
      sclk_q       <= 1'b0;
      low_cnt_q    <= 6'h00;
      since_fall_q <= 6'h3F;
      since_clk_q  <= 6'h3F;
    end else begin
      en_q         <= enable;
      sclk_q       <= serial_clk;
      since_clk_q  <= (sclk_q && !serial_clk) ? 6'h00 : since_clk_q + {5'h00, since_clk_q != 6'h3F};
      low_cnt_q    <= enable ? 6'h00 : low_cnt_q + {5'h00, low_cnt_q != 6'h3F};
      since_fall_q <= (en_q && !enable) ? 6'h00 : since_fall_q + {5'h00, since_fall_q != 6'h3F};
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_wake_all_on: assert property (
    hardware_wake_pin |-> &{channel_on_a, channel_on_b, channel_on_c, channel_on_d})
    else $error("wake pin high but a channel is off");
  a_reset_codes: assert property (
    $rose(nrst) |-> {output_a, output_b, output_c, output_d} == 32'h00000000)
    else $error("codes not zero after reset");
  a_reset_ctrl: assert property (
    $rose(nrst) |-> {gain_select_a, gain_select_b, gain_select_c, gain_select_d,
      single_mode, link_ready} == 6'h3D)
    else $error("control defaults wrong after reset");
  a_mode_sticky: assert property (
    single_mode |=> single_mode)
    else $error("single mode bit cleared");
  a_code_after_clk: assert property (
    single_mode && !$stable({output_a, output_b, output_c, output_d})
      |-> since_clk_q < 6'h18)
    else $error("code changed without serial clock fall in single mode");
  a_quiet_low: assert property (
    low_cnt_q > 6'h1E |-> $stable({output_a, output_b, output_c, output_d,
      gain_select_a, gain_select_b, gain_select_c, gain_select_d, single_mode}))
    else $error("outputs moved while enable low");
  a_code_after_fall: assert property (
    !single_mode && !$stable({output_a, output_b, output_c, output_d})
      |-> since_fall_q < 6'h18)
    else $error("code changed without enable fall in double mode");
  a_gain_after_fall: assert property (
    !single_mode && !$stable({gain_select_a, gain_select_b, gain_select_c, gain_select_d})
      |-> since_fall_q < 6'h18)
    else $error("gain changed without enable fall in double mode");
  a_mode_from_link: assert property (
    $rose(single_mode) |-> low_cnt_q < 6'h18)
    else $error("mode set while enable was low");
endmodule // qdc_top_properties
bind qdc_top qdc_top_properties u_props (
  .ref_clk(ref_clk), .nrst(nrst), .serial_clk(serial_clk), .serial_data(serial_data),
  .enable(enable), .hardware_wake_pin(hardware_wake_pin), .output_a(output_a),
  .output_b(output_b), .output_c(output_c), .output_d(output_d),
  .gain_select_a(gain_select_a), .gain_select_b(gain_select_b),
  .gain_select_c(gain_select_c), .gain_select_d(gain_select_d),
  .channel_on_a(channel_on_a), .channel_on_b(channel_on_b), .channel_on_c(channel_on_c),
  .channel_on_d(channel_on_d), .single_mode(single_mode), .link_ready(link_ready)
);
`default_nettype wire

// File: qdc_link_model.sv
// serial controller model that drives the converter link pins
`timescale 1ns/1ps
`default_nettype none
module qdc_link_model (
  input  wire logic ref_clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      enable
);
  // ---------------------------------------------------------------
  // pin drive, changed just after a ref_clk rising edge
  // ---------------------------------------------------------------
  // clock rests low outside bits so junk data never shifts in
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    enable      = 1'b0; // own enable for this device only
  end
  // half of the 320 ns link period
  task automatic half_period();
    repeat (4) @(posedge ref_clk);
  endtask
  // enable level, held at least one half period
  task automatic set_enable(input logic lvl);
    @(posedge ref_clk);
    enable <= lvl;
    half_period();
  endtask
  // top n bits of w, msb first; device takes each on the falling edge
  task automatic send_bits(input logic [11:0] w, input int n);
    for (int i = 11; i > 11 - n; i--) begin
      @(posedge ref_clk);
      serial_data <= w[i];
      serial_clk  <= 1'b1;
      half_period();
      serial_clk  <= 1'b0;
      // the next bit's leading edge completes the 320 ns period
      repeat (3) @(posedge ref_clk);
    end
    serial_data <= ~w[12-n]; // data no longer valid, shows no stale value
  endtask
  // whole words only, so every block has the same length
  task automatic send_word(input logic [11:0] w);
    send_bits(w, 12);
  endtask
endmodule // qdc_link_model
`default_nettype wire

// File: qdc_tb.sv
// self-checking bench for the quad converter serial control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed { logic [1:0] ch; logic [7:0] val; } qdc_row_s;
  localparam qdc_row_s ROWS [4] = '{'{2'h0, 8'hFF}, '{2'h1, 8'h5A}, '{2'h2, 8'h01},
                                    '{2'h3, 8'h80}};
  logic       ref_clk;
  logic       nrst;
  logic       wake;
  wire        sclk;
  wire        sdata;
  wire        sen;
  wire  [7:0] code [4];
  wire  [3:0] gain;
  wire  [3:0] on;
  wire        single_mode;
  wire        link_ready;
  int         n_errors;
  int         check_count;
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  qdc_link_model u_link (.ref_clk(ref_clk), .serial_clk(sclk), .serial_data(sdata),
    .enable(sen));
  qdc_top DUT (.ref_clk(ref_clk), .nrst(nrst), .serial_clk(sclk), .serial_data(sdata),
    .enable(sen), .hardware_wake_pin(wake), .output_a(code[0]), .output_b(code[1]),
    .output_c(code[2]), .output_d(code[3]), .gain_select_a(gain[0]),
    .gain_select_b(gain[1]), .gain_select_c(gain[2]), .gain_select_d(gain[3]),
    .channel_on_a(on[0]), .channel_on_b(on[1]), .channel_on_c(on[2]),
    .channel_on_d(on[3]), .single_mode(single_mode), .link_ready(link_ready));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check_code(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_flags(input logic [3:0] got, input logic [3:0] exp);
    check_code({4'h0, got}, {4'h0, exp});
  endtask
  // outputs settle about eight cycles after the pin; 24 leaves margin
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [11:0] data_word(input logic [1:0] ch, input logic [7:0] v);
    return {2'b10, ch, v};
  endfunction
  function automatic logic [11:0] ctrl_word(input logic m, input logic [3:0] g,
                                            input logic [3:0] h, input logic a);
    return {2'b11, m, g, h, a};
  endfunction
  // one word in its own enable frame
  task automatic frame(input logic [11:0] w);
    u_link.set_enable(1'b1);
    u_link.send_word(w);
    u_link.set_enable(1'b0);
    wait_cycles(24);
  endtask
  task automatic check_defaults();
    for (int i = 0; i < 4; i++) check_code(code[i], 8'h00);
    check_flags(gain, 4'hF);
    check_flags(on, 4'h0);
    check_flags({2'b00, single_mode, link_ready}, 4'h1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // whole sequence takes about 2000 cycles; over twelve times that is the limit
  initial begin
    wait_cycles(25000);
    n_errors++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    wake = 1'b0;
    n_errors = 0;
    check_count = 0;
    wait_cycles(16);
    nrst <= 1'b1;
    wait_cycles(6);
    check_defaults();
    wake <= 1'b1;
    wait_cycles(2);
    check_flags(on, 4'hF);
    wake <= 1'b0;
    // table rows: one data word per frame, boundary codes included
    foreach (ROWS[r]) begin
      frame(data_word(ROWS[r].ch, ROWS[r].val));
      check_code(code[ROWS[r].ch], ROWS[r].val);
    end
    // overwrite of a held code, then a partial word cut by the fall
    u_link.set_enable(1'b1);
    u_link.send_word(data_word(2'h0, 8'h11));
    u_link.send_word(data_word(2'h2, 8'h33));
    u_link.send_word(data_word(2'h0, 8'h22));
    wait_cycles(24);
    check_code(code[0], 8'hFF);
    u_link.send_bits(12'hB00, 6);
    u_link.set_enable(1'b0);
    wait_cycles(24);
    check_code(code[0], 8'h22);
    check_code(code[2], 8'h33);
    check_code(code[3], 8'h80);
    // clocking with enable low must load nothing
    u_link.send_word(data_word(2'h1, 8'hC3));
    wait_cycles(24);
    check_code(code[1], 8'h5A);
    // gain bits of a control word in double mode wait for the fall
    u_link.set_enable(1'b1);
    u_link.send_word(ctrl_word(1'b0, 4'hA, 4'h1, 1'b0));
    wait_cycles(24);
    check_flags(gain, 4'hF);
    u_link.set_enable(1'b0);
    wait_cycles(24);
    check_flags(gain, 4'hA);
    check_flags(on, 4'h1);
    frame(ctrl_word(1'b0, 4'h5, 4'h0, 1'b1));
    check_flags(on, 4'hF);
    check_flags(gain, 4'h5);
    // two-wire use: junk, twelve zeros, pending data, then mode set
    u_link.set_enable(1'b1);
    u_link.send_bits(12'hA80, 5);
    u_link.send_bits(12'h000, 12);
    u_link.send_word(data_word(2'h3, 8'h77));
    wait_cycles(24);
    check_code(code[3], 8'h80);
    u_link.send_word(ctrl_word(1'b1, 4'h0, 4'h0, 1'b0));
    wait_cycles(24);
    check_code(code[3], 8'h77);
    check_code(code[2], 8'h80);
    check_flags({single_mode, gain[2:0]}, 4'h8);
    u_link.send_word(data_word(2'h1, 8'hE7));
    wait_cycles(24);
    check_code(code[1], 8'hE7);
    u_link.send_word(ctrl_word(1'b0, 4'hF, 4'h0, 1'b0));
    wait_cycles(24);
    check_flags({single_mode, gain[2:0]}, 4'hF);
    // second reset in mid-run
    u_link.set_enable(1'b0);
    nrst <= 1'b0;
    wait_cycles(16);
    nrst <= 1'b1;
    wait_cycles(6);
    check_defaults();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
